// file: verilog/msw_regs.svh
// register map, field positions, reset values and timing for the multi stage watchdog
`ifndef MSW_REGS_SVH
`define MSW_REGS_SVH
// byte offsets
`define MSW_OFF_CTRL    8'h00
`define MSW_OFF_STAGE   8'h04
`define MSW_OFF_CMD     8'h08
`define MSW_OFF_STATUS  8'h0C
`define MSW_OFF_ISTAT   8'h10
`define MSW_OFF_ICLR    8'h14
`define MSW_OFF_IEN     8'h18
// ctrl fields
`define MSW_CTRL_POST   2:0
`define MSW_CTRL_HOLD   3
`define MSW_CTRL_MODE   5:4
`define MSW_CTRL_DELAY  8:6
`define MSW_CTRL_RSTRT  9
`define MSW_CTRL_UWAIT  10
`define MSW_CTRL_W      11
// stage fields
`define MSW_STG_T1      3:0
`define MSW_STG_T2      7:4
`define MSW_STG_T3      11:8
`define MSW_STG_E1      13:12
`define MSW_STG_E2      15:14
`define MSW_STG_E3      17:16
`define MSW_STG_W       18
// command bits
`define MSW_CMD_PSTART  0
`define MSW_CMD_PSTOP   1
`define MSW_CMD_ARM     2
`define MSW_CMD_TRIG    3
// interrupt events
`define MSW_IRQ_W       5
`define MSW_IRQ_POST    0
`define MSW_IRQ_STG1    1
`define MSW_IRQ_OFF     4
// reset values
`define MSW_CTRL_RST    11'h000
`define MSW_STG_RST     18'h00000
// code offsets into the shared seconds table
`define MSW_POST_BASE   4'h3
`define MSW_DLY_BASE    4'h2
// timing: a one second tick from a 5 ns clock
`define MSW_TICK_NS     1000000000
`define MSW_CLK_NS      5
`define MSW_SEC_W       11
`define MSW_PRE_W       28
`endif

// file: verilog/msw_pkg.sv
// types shared by the watchdog modules
package msw_pkg;
  typedef enum logic [1:0] {
    MSW_MODE_OFF,
    MSW_MODE_ONCE,
    MSW_MODE_SINGLE,
    MSW_MODE_REPEAT
  } msw_mode_e;

  typedef enum logic [1:0] {
    MSW_RT_OFF,
    MSW_RT_DELAY,
    MSW_RT_RUN
  } msw_rt_e;

  typedef struct packed {
    logic sys_reset;
    logic pwr_button;
    logic acpi_overtemp;
    logic acpi_fatal;
  } msw_act_s;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } msw_ahb_req_s;
endpackage : msw_pkg

// file: verilog/msw_tick.sv
// one second enable pulse from the system clock
`timescale 1ns/1ps
`include "msw_regs.svh"
module msw_tick #(
  parameter int TICK_CYCLES = `MSW_TICK_NS / `MSW_CLK_NS
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // control
  input  wire logic clr,
  // tick
  output logic      tick
);
  logic [`MSW_PRE_W-1:0] pre_r;
  logic                  wrap;

  assign wrap = (pre_r == `MSW_PRE_W'(TICK_CYCLES - 1));

  // clearing restarts a full second, so a load always counts whole seconds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= '0;
      tick  <= 1'b0;
    end else if (clr || wrap) begin
      pre_r <= '0;
      tick  <= wrap && !clr;
    end else begin
      pre_r <= pre_r + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule : msw_tick

// file: verilog/msw_top.sv
// multi stage watchdog: boot-time and three stage runtime watchdog behind AHB-Lite
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "msw_regs.svh"
////////////////////////////////////////////////////////////////////////////////
module msw_top
  import msw_pkg::*;
#(
  parameter int TICK_CYCLES = `MSW_TICK_NS / `MSW_CLK_NS
) (
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic               hready,
  input  wire logic [31:0]        hwdata,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // actions
  output msw_pkg::msw_act_s       act,
  // interrupt
  output logic                    irq
);
  import msw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // functions

  // seconds per code: 1,2,5,10,30,60,120,300,600,1800
  function automatic logic [`MSW_SEC_W-1:0] sec_of(input logic [3:0] code);
    case (code)
      4'h0:    sec_of = `MSW_SEC_W'd1;
      4'h1:    sec_of = `MSW_SEC_W'd2;
      4'h2:    sec_of = `MSW_SEC_W'd5;
      4'h3:    sec_of = `MSW_SEC_W'd10;
      4'h4:    sec_of = `MSW_SEC_W'd30;
      4'h5:    sec_of = `MSW_SEC_W'd60;
      4'h6:    sec_of = `MSW_SEC_W'd120;
      4'h7:    sec_of = `MSW_SEC_W'd300;
      4'h8:    sec_of = `MSW_SEC_W'd600;
      default: sec_of = `MSW_SEC_W'd1800;
    endcase
  endfunction : sec_of

  // stage codes above nine clamp to the longest time
  function automatic logic [`MSW_SEC_W-1:0] stage_sec(input logic [3:0] code);
    stage_sec = sec_of(code);
  endfunction : stage_sec

  // action pulses for one event code; no nmi encoding exists
  function automatic msw_act_s act_of(input logic [1:0] ev, input logic restart);
    act_of = '0;
    case (ev)
      2'h1: begin
        act_of.acpi_overtemp = !restart;
        act_of.acpi_fatal    = restart;
      end
      2'h2:    act_of.sys_reset  = 1'b1;
      2'h3:    act_of.pwr_button = 1'b1;
      default: act_of = '0;
    endcase
  endfunction : act_of

  ////////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave

  msw_ahb_req_s          req;
  logic                  wr_ph_r;
  logic [7:0]            wr_adr_r;
  logic                  acc;
  logic                  wr_ph;
  logic [31:0]           rd_nxt;

  logic [`MSW_CTRL_W-1:0] ctrl_r;
  logic [`MSW_STG_W-1:0]  stg_r;
  logic [`MSW_IRQ_W-1:0]  istat_r;
  logic [`MSW_IRQ_W-1:0]  ien_r;
  logic [`MSW_IRQ_W-1:0]  iclr;
  logic [`MSW_IRQ_W-1:0]  ev;
  logic [3:0]             cmd;

  assign req       = '{hsel, haddr, htrans, hwrite, hsize, hready};
  assign acc       = req.hsel && req.htrans[1] && req.hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_ph     = wr_ph_r;

  // zero wait states: every transfer completes in its first data cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_r  <= 1'b0;
      wr_adr_r <= 8'h00;
    end else begin
      wr_ph_r  <= acc && req.hwrite;
      wr_adr_r <= req.haddr[7:0];
    end
  end

  assign cmd  = (wr_ph && wr_adr_r == `MSW_OFF_CMD) ? hwdata[3:0] : 4'h0;
  assign iclr = (wr_ph && wr_adr_r == `MSW_OFF_ICLR) ? hwdata[`MSW_IRQ_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `MSW_CTRL_RST;
      stg_r  <= `MSW_STG_RST;
      ien_r  <= '0;
    end else if (wr_ph) begin
      case (wr_adr_r)
        `MSW_OFF_CTRL:  ctrl_r <= hwdata[`MSW_CTRL_W-1:0];
        `MSW_OFF_STAGE: stg_r  <= hwdata[`MSW_STG_W-1:0];
        `MSW_OFF_IEN:   ien_r  <= hwdata[`MSW_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // boot-time watchdog

  logic [2:0]             post_sel;
  logic                   post_run_r;
  logic [`MSW_SEC_W-1:0]  post_cnt_r;
  logic                   post_hold;
  logic                   post_tick;
  logic                   post_load;
  logic                   post_exp;

  assign post_sel  = ctrl_r[`MSW_CTRL_POST];
  assign post_hold = ctrl_r[`MSW_CTRL_HOLD] && ctrl_r[`MSW_CTRL_UWAIT];
  assign post_load = cmd[`MSW_CMD_PSTART] && post_sel != 3'h0;
  assign post_exp  = post_run_r && !post_hold && post_tick && post_cnt_r == `MSW_SEC_W'd1;

  msw_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_post_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (post_load || post_hold),
    .tick    (post_tick)
  );

  // selector codes 1..6 map to 30s..30min
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_run_r <= 1'b0;
      post_cnt_r <= '0;
    end else if (post_load) begin
      post_run_r <= 1'b1;
      post_cnt_r <= sec_of(4'(post_sel) + `MSW_POST_BASE);
    end else if (cmd[`MSW_CMD_PSTOP] || post_exp) begin
      post_run_r <= 1'b0;
    end else if (post_run_r && !post_hold && post_tick) begin
      post_cnt_r <= post_cnt_r - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // runtime watchdog

  msw_mode_e              mode;
  msw_rt_e                rt_r;
  logic [1:0]             stage_r;
  logic [`MSW_SEC_W-1:0]  rt_cnt_r;
  logic                   rt_tick;
  logic                   rt_load;
  logic                   rt_exp;
  logic                   trig;
  logic [1:0]             ev_cur;
  logic [1:0]             nxt_stage;
  logic                   nxt_ok;
  logic [3:0]             tsel [3];
  logic [2:0]             dly_sel;

  assign mode    = msw_mode_e'(ctrl_r[`MSW_CTRL_MODE]);
  assign dly_sel = ctrl_r[`MSW_CTRL_DELAY];
  assign tsel[0] = stg_r[`MSW_STG_T1];
  assign tsel[1] = stg_r[`MSW_STG_T2];
  assign tsel[2] = stg_r[`MSW_STG_T3];
  assign trig    = cmd[`MSW_CMD_TRIG] && rt_r == MSW_RT_RUN;
  assign rt_exp  = rt_r != MSW_RT_OFF && rt_tick && rt_cnt_r == `MSW_SEC_W'd1;

  // stage one codes 0..2 shift up one: acpi, reset, button; never none
  always_comb begin
    case (stage_r)
      // code 3 would wrap to none, so it stays on the power button
      2'h0:    ev_cur = (stg_r[`MSW_STG_E1] == 2'h3) ? 2'h3 : stg_r[`MSW_STG_E1] + 2'h1;
      2'h1:    ev_cur = stg_r[`MSW_STG_E2];
      default: ev_cur = stg_r[`MSW_STG_E3];
    endcase
  end

  // a stage with event none is skipped
  always_comb begin
    nxt_ok    = 1'b0;
    nxt_stage = stage_r;
    if (stage_r == 2'h0 && stg_r[`MSW_STG_E2] != 2'h0) begin
      nxt_ok    = 1'b1;
      nxt_stage = 2'h1;
    end else if (stage_r != 2'h2 && stg_r[`MSW_STG_E3] != 2'h0) begin
      nxt_ok    = 1'b1;
      nxt_stage = 2'h2;
    end
  end

  assign rt_load = (cmd[`MSW_CMD_ARM] && rt_r == MSW_RT_OFF && mode != MSW_MODE_OFF) || trig ||
                   (rt_exp && (rt_r == MSW_RT_DELAY || nxt_ok || mode == MSW_MODE_REPEAT));

  msw_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_rt_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (rt_load),
    .tick    (rt_tick)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rt_r     <= MSW_RT_OFF;
      stage_r  <= 2'h0;
      rt_cnt_r <= '0;
    end else begin
      case (rt_r)
        MSW_RT_OFF: begin
          if (cmd[`MSW_CMD_ARM] && mode != MSW_MODE_OFF) begin
            stage_r <= 2'h0;
            if (dly_sel == 3'h0) begin
              rt_r     <= MSW_RT_RUN;
              rt_cnt_r <= stage_sec(tsel[0]);
            end else begin
              rt_r     <= MSW_RT_DELAY;
              rt_cnt_r <= sec_of(4'(dly_sel) + `MSW_DLY_BASE);
            end
          end
        end
        MSW_RT_DELAY: begin
          // triggers are ignored while the os is still loading
          if (rt_exp) begin
            rt_r     <= MSW_RT_RUN;
            rt_cnt_r <= stage_sec(tsel[0]);
          end else if (rt_tick) begin
            rt_cnt_r <= rt_cnt_r - 1'b1;
          end
        end
        MSW_RT_RUN: begin
          if (trig && mode == MSW_MODE_ONCE) begin
            rt_r <= MSW_RT_OFF;
          end else if (trig) begin
            stage_r  <= 2'h0;
            rt_cnt_r <= stage_sec(tsel[0]);
          end else if (rt_exp && nxt_ok) begin
            stage_r  <= nxt_stage;
            rt_cnt_r <= stage_sec(tsel[nxt_stage]);
          end else if (rt_exp && mode == MSW_MODE_REPEAT) begin
            rt_cnt_r <= stage_sec(tsel[stage_r]);
          end else if (rt_exp) begin
            rt_r <= MSW_RT_OFF;
          end else if (rt_tick) begin
            rt_cnt_r <= rt_cnt_r - 1'b1;
          end
        end
        default: rt_r <= MSW_RT_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // actions

  msw_act_s act_nxt;

  always_comb begin
    act_nxt = '0;
    if (rt_exp && rt_r == MSW_RT_RUN) begin
      act_nxt = act_of(ev_cur, ctrl_r[`MSW_CTRL_RSTRT]);
    end
    if (post_exp) begin
      act_nxt.sys_reset = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act <= '0;
    end else begin
      act <= act_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts

  logic rt_stops;

  assign rt_stops = rt_r == MSW_RT_RUN &&
                    ((trig && mode == MSW_MODE_ONCE) ||
                     (rt_exp && !trig && !nxt_ok && mode != MSW_MODE_REPEAT));

  always_comb begin
    ev = '0;
    ev[`MSW_IRQ_POST] = post_exp;
    if (rt_exp && rt_r == MSW_RT_RUN && !trig) begin
      ev[`MSW_IRQ_STG1 + 32'(stage_r)] = 1'b1;
    end
    ev[`MSW_IRQ_OFF] = rt_stops;
  end

  // a new event in the clearing cycle stays set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_r <= '0;
    end else begin
      istat_r <= (istat_r & ~iclr) | ev;
    end
  end

  assign irq = |(istat_r & ien_r);

  ////////////////////////////////////////////////////////////////////////////////
  // read data

  always_comb begin
    case (req.haddr[7:0])
      `MSW_OFF_CTRL:   rd_nxt = 32'(ctrl_r);
      `MSW_OFF_STAGE:  rd_nxt = 32'(stg_r);
      `MSW_OFF_STATUS: rd_nxt = {post_cnt_r, 5'h00, rt_cnt_r, post_run_r, stage_r, rt_r};
      `MSW_OFF_ISTAT:  rd_nxt = 32'(istat_r);
      `MSW_OFF_IEN:    rd_nxt = 32'(ien_r);
      default:         rd_nxt = 32'h0000_0000;
    endcase
  end

  // registered in the address phase so data stand from the data phase start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !req.hwrite) begin
      hrdata <= rd_nxt;
    end
  end
endmodule : msw_top

// file: test/msw_monitor.sv
// port-level assertions for the watchdog
`timescale 1ns/1ps
`include "msw_regs.svh"
module msw_monitor
  import msw_pkg::*;
#(
  parameter int TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic              hclk,
  input wire logic              hresetn,
  // bus
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic              hready,
  input wire logic [31:0]       hwdata,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  // outputs
  input wire msw_pkg::msw_act_s act,
  input wire logic              irq
);
  logic rd_taken;
  assign rd_taken = hsel && htrans[1] && !hwrite && hready;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////
  chk_ready_high: assert property (hreadyout) else $error("wait state seen");
  chk_resp_okay: assert property (!hresp) else $error("error response seen");
  chk_reset_quiet: assert property ($rose(hresetn) |-> !(|act) && !irq) else $error("busy after reset");
  chk_act_onehot: assert property ($onehot0(act)) else $error("two actions at once");
  // a stage lasts at least one second, so pulses never sit closer
  chk_act_gap: assert property ((|act) |=> !(|act) [*8]) else $error("action not a lone pulse");
  chk_unmapped_zero: assert property (rd_taken && haddr[7:0] == 8'h1C |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_wo_zero: assert property (rd_taken && (haddr[7:0] == `MSW_OFF_CMD || haddr[7:0] == `MSW_OFF_ICLR)
    |=> hrdata == 32'h0) else $error("write-only read not zero");
  chk_rdata_hold: assert property (!rd_taken |=> $stable(hrdata)) else $error("read data moved");
endmodule : msw_monitor

// file: test/msw_top_test.sv
// self-checking bench for the multi stage watchdog
`timescale 1ns/1ps
`include "msw_regs.svh"
module msw_top_test;
  import msw_pkg::*;
  localparam int TK = 10;
  localparam int SECS [10] = '{1, 2, 5, 10, 30, 60, 120, 300, 600, 1800};
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  msw_act_s    act;
  int          num_errors, checked, seed, n, c;

  msw_top #(.TICK_CYCLES(TK)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .act(act), .irq(irq));

  initial hclk = 1'b0;
  always #2.5 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic int cyc(input int code);
    return SECS[code] * TK;
  endfunction : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    #1;
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q & mask, exp);
  endtask : rdc

  // waits for one action pulse; too early or too late both show
  task automatic wact(input logic [3:0] m, input int lo, input int hi, input logic [3:0] e);
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while ((4'(act) & m) == 4'h0 && n < hi);
    chk({27'h0, n >= lo, 4'(act)}, {27'h0, 1'b1, e});
  endtask : wact

  task automatic complete_run;
    $display("errors %0d, checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    complete_run();
  end

  initial begin
    seed = 89;
    {hsel, hwrite, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    hresetn = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`MSW_OFF_CTRL, 32'hFFFFFFFF, 32'h0);
    rdc(`MSW_OFF_STAGE, 32'hFFFFFFFF, 32'h0);
    rdc(8'h1C, 32'hFFFFFFFF, 32'h0);
    // boot watchdog frozen while the user is busy, then expires
    bus(1'b1, `MSW_OFF_IEN, 32'h1F);
    bus(1'b1, `MSW_OFF_CTRL, 32'h409);
    bus(1'b1, `MSW_OFF_CMD, 32'h1);
    rdc(`MSW_OFF_STATUS, 32'h10, 32'h10);
    wact(4'h8, 0, cyc(4) + 20, 4'h0);
    bus(1'b1, `MSW_OFF_CTRL, 32'h001);
    wact(4'h8, cyc(4), cyc(4) + 4, 4'h8);
    chk(32'(irq), 32'h1);
    rdc(`MSW_OFF_STATUS, 32'h10, 32'h0);
    bus(1'b1, `MSW_OFF_ICLR, 32'h1F);
    chk(32'(irq), 32'h0);
    // single event: every stage once, random second timeout
    c = {$random(seed)} % 4;
    bus(1'b1, `MSW_OFF_STAGE, {14'h0, 2'h2, 2'h1, 2'h2, 4'h0, 4'(c), 4'h1});
    bus(1'b1, `MSW_OFF_CTRL, 32'h220);
    bus(1'b1, `MSW_OFF_CMD, 32'h4);
    wact(4'h4, cyc(1), cyc(1) + 4, 4'h4);
    wact(4'h1, cyc(c), cyc(c) + 4, 4'h1);
    wact(4'h8, cyc(0), cyc(0) + 4, 4'h8);
    rdc(`MSW_OFF_STATUS, 32'h3, 32'h0);
    rdc(`MSW_OFF_ISTAT, 32'h1F, 32'h1E);
    bus(1'b1, `MSW_OFF_ICLR, 32'h1F);
    // repeated event: silent stage two skipped, last stage repeats
    bus(1'b1, `MSW_OFF_STAGE, {14'h0, 2'h1, 2'h0, 2'h0, 4'h0, 4'h1, 4'h0});
    bus(1'b1, `MSW_OFF_CTRL, 32'h030);
    bus(1'b1, `MSW_OFF_CMD, 32'h4);
    wact(4'h2, cyc(0), cyc(0) + 4, 4'h2);
    repeat (3) wact(4'h2, cyc(0), cyc(0) + 4, 4'h2);
    bus(1'b1, `MSW_OFF_CMD, 32'h8);
    rdc(`MSW_OFF_STATUS, 32'hF, 32'h2);
    // reset in mid-run clears everything
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`MSW_OFF_STATUS, 32'h1F, 32'h0);
    bus(1'b1, `MSW_OFF_CMD, 32'h4);
    rdc(`MSW_OFF_STATUS, 32'h3, 32'h0);
    // one-time trigger after a start delay
    bus(1'b1, `MSW_OFF_STAGE, 32'h4);
    bus(1'b1, `MSW_OFF_CTRL, 32'h050);
    bus(1'b1, `MSW_OFF_CMD, 32'h4);
    rdc(`MSW_OFF_STATUS, 32'h3, 32'h1);
    bus(1'b1, `MSW_OFF_CMD, 32'h8);
    repeat (cyc(2)) @(posedge hclk);
    rdc(`MSW_OFF_STATUS, 32'h3, 32'h1);
    repeat (cyc(3) - cyc(2)) @(posedge hclk);
    rdc(`MSW_OFF_STATUS, 32'h3, 32'h2);
    bus(1'b1, `MSW_OFF_CMD, 32'h8);
    rdc(`MSW_OFF_STATUS, 32'h3, 32'h0);
    complete_run();
  end
endmodule : msw_top_test

bind msw_top msw_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .act(act), .irq(irq));
